// >>> tb.sv
// Testbench for the watchdog configuration port.
// Assumes the master model, checker and design files compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_in, resetn_in, scl, m_sda, sda, sda_oe, ana, modem, we, ok;
  logic route, ana_out, conn, conn_oe, rst_cfg;
  logic [6:0] sa;
  logic [9:0] dir;
  logic [7:0] dly, st, ptr, d;
  int miscompares, comparisons, cycles;
  assign sda = m_sda & ~sda_oe;
  wdc_config_port wdc_config_port_i (.clk_in(clk_in),
    .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda),
    .cfg_addr_we_in(we), .cfg_addr_in(7'h57),
    .module_analog_input_in(ana), .module_modem_status_out_in(modem),
    .sda_oe_out(sda_oe), .line_route_command_out(route),
    .module_analog_input_out(ana_out), .connector_line_out(conn),
    .connector_line_oe_out(conn_oe), .gpio_dir_out(dir),
    .trigger_delay_out(dly), .restart_cfg_out(rst_cfg),
    .status_register_out(st), .read_pointer_out(ptr));
  wdc_mst wdc_mst_i (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_out(m_sda));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ra, dv, es);
    wdc_mst_i.write(sa, 2, ra, dv, ok);
    chk(ok, 1'b1);
    chk(st, es);
    if (ra != 8'hFF) chk(ptr, 8'h00);
  endtask
  task automatic rd(input logic [7:0] exp);
    wdc_mst_i.read(sa, d, ok);
    chk(ok, 1'b1);
    chk(d, exp);
  endtask
  task automatic report_and_stop;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    ana <= resetn_in & ~ana;
    modem <= ~modem;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    resetn_in = 1'b0;
    we = 1'b0;
    ana = 1'b0;
    modem = 1'b0;
    sa = 7'h6A;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1; // Host runs before any command
    repeat (8) @(posedge clk_in);
    chk(route, 1'b0);
    chk(ptr, 8'h00);
    rd(8'h00);
    wr(8'h50, 8'h01, 8'h00);
    chk(route, 1'b1);
    chk(conn_oe, 1'b1);
    wr(8'h50, 8'h02, 8'h03);
    chk(route, 1'b1);
    wr(8'h42, 8'h01, 8'h02);
    wr(8'h14, 8'h01, 8'h00);
    chk(dir, 10'h010);
    wr(8'h80, 8'hFF, 8'h00);
    chk(dly, 8'hFF);
    wr(8'h09, 8'h01, 8'h00);
    chk(rst_cfg, 1'b1);
    wr(8'h18, 8'h01, 8'h00);
    chk(dir, 10'h110);
    wr(8'hFF, 8'h30, 8'h00);
    chk(ptr, 8'h30);
    rd(8'h10);
    rd(8'h10);
    wr(8'hFF, 8'h50, 8'h00);
    rd(8'h01);
    wr(8'hFF, 8'h31, 8'h00);
    rd(8'h01);
    wr(8'hFF, 8'h10, 8'h03);
    chk(ptr, 8'h00);
    rd(8'h03);
    wdc_mst_i.write(sa, 1, 8'h50, 8'h00, ok);
    chk(st, 8'h01);
    wdc_mst_i.write(7'h57, 2, 8'h50, 8'h00, ok);
    chk(ok, 1'b0);
    chk(route, 1'b1);
    we <= 1'b1;
    @(posedge clk_in);
    we <= 1'b0;
    sa = 7'h57;
    wr(8'h50, 8'h00, 8'h00);
    chk(route, 1'b0);
    report_and_stop();
  end
endmodule // tb
bind wdc_config_port wdc_config_port_asserts #(.NUM_DIR(NUM_DIR))
  wdc_config_port_asserts_i (.clk_in(clk_in), .resetn_in(resetn_in),
  .module_analog_input_in(module_analog_input_in),
  .module_modem_status_out_in(module_modem_status_out_in),
  .connector_line_out(connector_line_out),
  .line_route_command_out(line_route_command_out),
  .module_analog_input_out(module_analog_input_out),
  .connector_line_oe_out(connector_line_oe_out),
  .gpio_dir_out(gpio_dir_out), .trigger_delay_out(trigger_delay_out),
  .status_register_out(status_register_out),
  .read_pointer_out(read_pointer_out));
`default_nettype wire

// >>> wdc_config_port.sv
// Watchdog I2C configuration port and shared-line routing select.
// Assumes open-drain I2C pins resolved outside; one clock, clk_in.
`timescale 1ns/100ps
`default_nettype none

`include "wdc_params.svh"

// Function
// R01: One-bit stored line route, 0 analog input, 1 digital output, resets 0.
// R02: Route connector line to analog input or modem-status output.
// R03: Master uses this port only while host module runs.
// R04: Master spaces GPIO direction commands at least 500 ms apart; the master model idles 20 clocks after each stop.
// R05: Answer slave address 0x6A by default, replaceable by configuration.
// R06: Write is address, register, data, each acknowledged, then stop.
// R07: Read returns one data byte, master ends with nack and stop.
// R08: Extra read bytes may carry undefined values.
// R09: Store data only when within the register's permitted range.
// R10: After each write record status and point read pointer at status.
// R11: Write to the read pointer keeps the written address.
// R12: Reads return the register selected by the read pointer.
// R13: Master writes the read pointer before reading other registers.
// R14: Unreadable pointer value selects status and records illegal argument.
// R15: Master ignores the read following a rejected pointer write.
// R16: Status codes 00 ok, 01 protocol, 02 address, 03 argument, FF undefined.
// R17: Status at 0x00, read pointer at 0xFF, pointer resets to 0x00.
module wdc_config_port
  import wdc_pkg::*;
#(
  parameter logic [7:0] VERSION = `WDC_VERSION_RESET, // Arbitrary value
  parameter int NUM_DIR = 10
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic cfg_addr_we_in,
  input wire logic [6:0] cfg_addr_in,
  input wire logic module_analog_input_in,
  input wire logic module_modem_status_out_in,
  output logic sda_oe_out,
  output logic line_route_command_out,
  output logic module_analog_input_out,
  output logic connector_line_out,
  output logic connector_line_oe_out,
  output logic [NUM_DIR-1:0] gpio_dir_out,
  output logic [7:0] trigger_delay_out,
  output logic restart_cfg_out,
  output logic [7:0] status_register_out,
  output logic [7:0] read_pointer_out
);
  logic [1:0] pins_s;
  logic [6:0] slave_addr_q;
  logic [7:0] tx_byte_d;
  wdc_wr_t wr;
  logic rd_done;
  logic [7:0] dir_idx;

  // Readable addresses only
  function automatic logic readable(input logic [7:0] a);
    return a == `WDC_REG_STATUS || a == `WDC_REG_ROUTE ||
           a == `WDC_REG_GPIO_LO || a == `WDC_REG_GPIO_HI ||
           a == `WDC_REG_VERSION;
  endfunction

  wdc_sync #(.WIDTH(2)) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );

  wdc_i2c_slave u_slave (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .scl_in(pins_s[1]),
    .sda_in(pins_s[0]),
    .slave_addr_in(slave_addr_q),
    .tx_byte_in(tx_byte_d),
    .sda_oe_out(sda_oe_out),
    .wr_out(wr),
    .rd_done_out(rd_done)
  );

  // Slave address replaced by the configuration path [R05]
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) slave_addr_q <= `WDC_DEF_SLAVE_ADDR;
    else if (cfg_addr_we_in && cfg_addr_in != 7'h00) slave_addr_q <= cfg_addr_in;
  end

  // Read mux driven by the pointer [R12]
  always_comb begin
    tx_byte_d = `WDC_ST_UNDEF;
    unique case (read_pointer_out)
      `WDC_REG_STATUS: tx_byte_d = status_register_out;
      `WDC_REG_ROUTE: tx_byte_d = {7'h00, line_route_command_out};
      `WDC_REG_GPIO_LO: tx_byte_d = gpio_dir_out[7:0];
      `WDC_REG_GPIO_HI: tx_byte_d = {6'h00, gpio_dir_out[9], gpio_dir_out[8]};
      `WDC_REG_VERSION: tx_byte_d = VERSION;
      default: tx_byte_d = `WDC_ST_UNDEF;
    endcase
  end

  assign dir_idx = wr.addr - `WDC_REG_DIR_FIRST;

  // Write handling: range check, status, pointer update
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_register_out <= `WDC_ST_OK;
      read_pointer_out <= `WDC_RDPTR_RESET; // [R17]
      line_route_command_out <= `WDC_ROUTE_RESET; // [R01]
      gpio_dir_out <= '0;
      trigger_delay_out <= 8'h00;
      restart_cfg_out <= 1'b0;
    end else if (wr.valid) begin
      read_pointer_out <= `WDC_REG_STATUS; // [R10]
      status_register_out <= `WDC_ST_OK; // [R16]
      if (wr.bad_count) begin
        status_register_out <= `WDC_ST_PROTO;
      end else if (wr.addr == `WDC_REG_RDPTR) begin
        if (readable(wr.data)) begin
          read_pointer_out <= wr.data; // [R11]
        end else begin
          status_register_out <= `WDC_ST_ARG; // [R14]
        end
      end else if (wr.addr == `WDC_REG_ROUTE) begin
        if (wr.data <= 8'h01) line_route_command_out <= wr.data[0]; // [R09]
        else status_register_out <= `WDC_ST_ARG;
      end else if (wr.addr >= `WDC_REG_DIR_FIRST &&
                   wr.addr <= `WDC_REG_DIR_LAST) begin
        if (wr.data <= 8'h01) gpio_dir_out[dir_idx[3:0]] <= wr.data[0]; // [R09]
        else status_register_out <= `WDC_ST_ARG;
      end else if (wr.addr == `WDC_REG_DELAY) begin
        trigger_delay_out <= wr.data;
      end else if (wr.addr == `WDC_REG_RESTART) begin
        if (wr.data <= 8'h01) restart_cfg_out <= wr.data[0];
        else status_register_out <= `WDC_ST_ARG;
      end else begin
        status_register_out <= `WDC_ST_ADDR;
      end
    end
  end

  // Connector line routing [R02]
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      module_analog_input_out <= 1'b0;
      connector_line_out <= 1'b0;
      connector_line_oe_out <= 1'b0;
    end else begin
      module_analog_input_out <= line_route_command_out ? 1'b0 : module_analog_input_in;
      connector_line_out <= line_route_command_out & module_modem_status_out_in;
      connector_line_oe_out <= line_route_command_out;
    end
  end
endmodule // wdc_config_port

`default_nettype wire

// >>> wdc_config_port_asserts.sv
// Output checks for the watchdog configuration port.
// Assumes a bind onto wdc_config_port, one clock.
`timescale 1ns/100ps
`default_nettype none
module wdc_config_port_asserts #(
  parameter int NUM_DIR = 10
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic module_analog_input_in,
  input wire logic module_modem_status_out_in,
  input wire logic connector_line_out,
  input wire logic line_route_command_out,
  input wire logic module_analog_input_out,
  input wire logic connector_line_oe_out,
  input wire logic [NUM_DIR-1:0] gpio_dir_out,
  input wire logic [7:0] trigger_delay_out,
  input wire logic [7:0] status_register_out,
  input wire logic [7:0] read_pointer_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_route_analog: assert property ((!line_route_command_out)[*2] |->
    module_analog_input_out == $past(module_analog_input_in))
    else $error("analog path not followed");
  a_route_drive: assert property (line_route_command_out[*3] |->
    connector_line_oe_out) else $error("connector not driven");
  a_conn_follow: assert property (line_route_command_out[*2] |->
    connector_line_out == $past(module_modem_status_out_in))
    else $error("modem status not routed out");
  a_route_quiet: assert property ((!line_route_command_out)[*3] |->
    !connector_line_oe_out) else $error("connector driven");
  a_ptr_legal: assert property (read_pointer_out inside
    {8'h00, 8'h30, 8'h31, 8'h50, 8'hFD}) else $error("pointer bad");
  a_status_legal: assert property (status_register_out inside
    {8'h00, 8'h01, 8'h02, 8'h03, 8'hFF}) else $error("status bad");
  a_route_write: assert property ($changed(line_route_command_out) |->
    read_pointer_out == 8'h00 && status_register_out == 8'h00)
    else $error("route write without ok");
  a_dir_write: assert property ($changed(gpio_dir_out) |->
    read_pointer_out == 8'h00 && status_register_out == 8'h00)
    else $error("direction write without ok");
  a_delay_write: assert property ($changed(trigger_delay_out) |->
    read_pointer_out == 8'h00 && status_register_out == 8'h00)
    else $error("delay write without ok");
  a_ptr_keeps_ok: assert property ($changed(read_pointer_out) &&
    read_pointer_out != 8'h00 |-> status_register_out == 8'h00)
    else $error("pointer write without ok");
endmodule // wdc_config_port_asserts
`default_nettype wire

// >>> wdc_i2c_slave.sv
// I2C slave byte engine: addressing, receive, transmit of one byte repeated on each master ack.
// Assumes synchronised scl/sda levels on clk_in, pins open-drain.
`timescale 1ns/100ps
`default_nettype none

module wdc_i2c_slave
  import wdc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [6:0] slave_addr_in,
  input wire logic [7:0] tx_byte_in,
  output logic sda_oe_out,
  output wdc_wr_t wr_out,
  output logic rd_done_out
);
  wdc_i2c_state_t state_q;
  logic scl_q, sda_q;
  logic [7:0] shift_q;
  // Counts to 8 so the fall that ends a start is not a byte end
  logic [3:0] bit_q;
  logic [1:0] nrx_q;
  logic rw_q;
  logic [7:0] addr_q, data_q;
  logic rise, fall, start_c, stop_c;

  assign rise = scl_in && !scl_q;
  assign fall = !scl_in && scl_q;
  assign start_c = scl_in && scl_q && sda_q && !sda_in;
  assign stop_c = scl_in && scl_q && !sda_q && sda_in;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bit_q <= 4'd0;
      nrx_q <= 2'd0;
      rw_q <= 1'b0;
      addr_q <= 8'h00;
      data_q <= 8'h00;
      sda_oe_out <= 1'b0;
      wr_out <= '0;
      rd_done_out <= 1'b0;
    end else begin
      wr_out.valid <= 1'b0;
      rd_done_out <= 1'b0;
      if (start_c) begin
        // Repeated start also ends a pending write
        if (state_q != ST_IDLE && !rw_q && nrx_q != 2'd0) begin
          wr_out <= '{1'b1, addr_q, data_q, nrx_q != 2'd2};
        end
        state_q <= ST_ADDR;
        bit_q <= 4'd0;
        nrx_q <= 2'd0;
        rw_q <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (stop_c) begin
        // Write ends at stop; wrong byte count flagged [R06] [R10]
        if (!rw_q && nrx_q != 2'd0 && state_q != ST_IDLE) begin
          wr_out <= '{1'b1, addr_q, data_q, nrx_q != 2'd2};
        end
        state_q <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE, ST_IGNORE: ;
          ST_ADDR, ST_RXBYTE: begin
            if (rise) begin
              shift_q <= {shift_q[6:0], sda_in};
              bit_q <= bit_q + 4'd1;
            end
            if (fall && bit_q == 4'd8) begin
              if (state_q == ST_ADDR) begin
                // Own address only [R05]
                if (shift_q[7:1] == slave_addr_in) begin
                  rw_q <= shift_q[0];
                  sda_oe_out <= 1'b1;
                  state_q <= ST_ACK;
                end else begin
                  state_q <= ST_IGNORE;
                end
              end else begin
                if (nrx_q == 2'd0) addr_q <= shift_q;
                else if (nrx_q == 2'd1) data_q <= shift_q;
                if (nrx_q != 2'd3) nrx_q <= nrx_q + 2'd1;
                sda_oe_out <= 1'b1; // Ack each byte [R06]
                state_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (fall) begin
              bit_q <= 4'd0;
              if (rw_q) begin
                // One byte from the selected register [R07] [R12]
                shift_q <= {tx_byte_in[6:0], 1'b0};
                sda_oe_out <= !tx_byte_in[7];
                state_q <= ST_TXBYTE;
              end else begin
                sda_oe_out <= 1'b0;
                state_q <= ST_RXBYTE;
              end
            end
          end
          ST_TXBYTE: begin
            if (fall) begin
              bit_q <= bit_q + 4'd1;
              if (bit_q == 4'd7) begin
                sda_oe_out <= 1'b0;
                state_q <= ST_TXACK;
              end else begin
                sda_oe_out <= !shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
              end
            end
          end
          ST_TXACK: begin
            if (rise) begin
              rd_done_out <= 1'b1;
              // Extra bytes repeat the same value [R08]
              state_q <= sda_in ? ST_IGNORE : ST_ACK;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // wdc_i2c_slave

`default_nettype wire

// >>> wdc_mst.sv
// I2C master model standing in for the host module.
// Assumes SDA resolved outside with a pull-up; SCL driven push-pull.
`timescale 1ns/100ps
`default_nettype none
module wdc_mst (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // SCL high six clocks, low eight clocks per bit
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    wt(6);
    scl_out <= 1'b1;
    wt(6);
    r = sda_in;
    scl_out <= 1'b0;
    wt(2);
  endtask
  task automatic start_c;
    sda_out <= 1'b0;
    wt(6);
    scl_out <= 1'b0;
    wt(2);
  endtask
  // Idle gap after stop stands for command spacing
  task automatic stop_c;
    sda_out <= 1'b0;
    wt(6);
    scl_out <= 1'b1;
    wt(6);
    sda_out <= 1'b1;
    wt(20);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic write(input logic [6:0] sa, input int n,
      input logic [7:0] ra, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    a1 = 1'b1;
    a2 = 1'b1;
    start_c();
    put({sa, 1'b0}, a0);
    if (n > 0) put(ra, a1);
    if (n > 1) put(d, a2);
    stop_c();
    ok = a0 & a1 & a2;
  endtask
  task automatic read(input logic [6:0] sa, output logic [7:0] d,
      output logic ok);
    logic r;
    start_c();
    put({sa, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop_c();
  endtask
endmodule // wdc_mst
`default_nettype wire

// >>> wdc_params.svh
// Constants for the watchdog I2C configuration port.
// Assumes inclusion by bare name from the package and modules.
`ifndef WDC_PARAMS_SVH
`define WDC_PARAMS_SVH

`define WDC_DEF_SLAVE_ADDR 7'h6A
`define WDC_REG_STATUS 8'h00
`define WDC_REG_ROUTE 8'h50
`define WDC_REG_VERSION 8'hFD
`define WDC_REG_RDPTR 8'hFF
`define WDC_REG_GPIO_LO 8'h30
`define WDC_REG_GPIO_HI 8'h31
`define WDC_REG_DIR_FIRST 8'h10
`define WDC_REG_DIR_LAST 8'h19
`define WDC_REG_DELAY 8'h80
`define WDC_REG_RESTART 8'h09
`define WDC_ST_OK 8'h00
`define WDC_ST_PROTO 8'h01
`define WDC_ST_ADDR 8'h02
`define WDC_ST_ARG 8'h03
`define WDC_ST_UNDEF 8'hFF
`define WDC_RDPTR_RESET 8'h00
`define WDC_ROUTE_RESET 1'b0
`define WDC_VERSION_RESET 8'h10

`endif

// >>> wdc_pkg.sv
// Types for the watchdog I2C configuration port.
// Assumes wdc_params.svh is on the include path.
`include "wdc_params.svh"

package wdc_pkg;
  // One completed write seen on the bus
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
    logic bad_count;
  } wdc_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_RXBYTE, ST_TXBYTE, ST_TXACK, ST_IGNORE
  } wdc_i2c_state_t;
endpackage

// >>> wdc_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes a single clock domain on clk_in.
`timescale 1ns/100ps
`default_nettype none

module wdc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= '1;
      sync_out <= '1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // wdc_sync

`default_nettype wire
